// ===== src/cam_top.v
// clock accuracy monitor: counts a target clock over reference periods and checks limits
// What this block does
// - count target pulses per reference period, judge range
// - three separate interrupt requests: end, error, overflow
// - control bit 0 enables measurement, others read zero
// - enable write delayed; repeat writes ignored meanwhile
// - bit 0 gates the external reference pin
// - bits 3..1 pick the measured clock
// - bits 5..4 pick counter prescale 1/4/8/32
// - bits 7..6 pick rising, falling or both edges
// - bit 0 picks pin or internal reference
// - bits 3..1 pick internal reference clock source
// - bits 5..4 divide internal reference 32..8192
// - bits 7..6 pick digital filter sampling rate
// - module stop halts the measurement logic
// - error when capture above upper or below lower
// - capture counter into read-only buffer each edge after the first
// - flags cleared by writing one; clear bits read zero
// - counting starts at first valid reference edge
//
// Added by the designer: the plain strobed port.
`timescale 1ns/1ps
`include "cam_consts.vh"

module cam_top #(
    parameter EN_DELAY = `CAM_EN_DELAY_CYC
) (
    // clock and reset
    input wire clk_sys,
    input wire reset_n,
    // low power
    input wire module_stop,
    // clocks under measurement and reference pin, asynchronous
    input wire main_clock,
    input wire high_speed_onchip_osc,
    input wire low_speed_onchip_osc,
    input wire watchdog_dedicated_clock,
    input wire peripheral_clock_b,
    input wire ext_reference_pin,
    // register port
    input wire [`CAM_ADDR_W-1:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [7:0] reg_rdata,
    // interrupt requests
    output reg irq_freq_error,
    output reg irq_measure_end,
    output reg irq_overflow
);

    localparam ST_IDLE = 2'd0;
    localparam ST_ARM = 2'd1;
    localparam ST_RUN = 2'd2;
    localparam NSRC = 6;

    // source index picked by a 3-bit select code; prohibited codes fall back to main
    function [2:0] clk_index;
        input [2:0] code;
        begin
            case (code)
                3'h2: clk_index = 3'd1;
                3'h3: clk_index = 3'd2;
                3'h4: clk_index = 3'd3;
                3'h5: clk_index = 3'd4;
                default: clk_index = 3'd0;
            endcase
        end
    endfunction

    // reset release
    reg rst_meta_r;
    reg rst_n_r;
    always @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            rst_meta_r <= 1'b0;
            rst_n_r <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_n_r <= rst_meta_r;
        end
    end

    // input synchronisers: a level counts once stages two and three agree
    wire [NSRC-1:0] raw_in;
    reg [NSRC-1:0] sync1_r;
    reg [NSRC-1:0] sync2_r;
    reg [NSRC-1:0] sync3_r;
    reg [NSRC-1:0] lvl_r;
    reg [NSRC-1:0] lvl_prev_r;
    wire [NSRC-1:0] rise;
    assign raw_in = {ext_reference_pin, peripheral_clock_b, watchdog_dedicated_clock,
                     low_speed_onchip_osc, high_speed_onchip_osc, main_clock};
    genvar gi;
    generate
        for (gi = 0; gi < NSRC; gi = gi + 1) begin : g_sync
            always @(posedge clk_sys or negedge rst_n_r) begin
                if (!rst_n_r) begin
                    sync1_r[gi] <= 1'b0;
                    sync2_r[gi] <= 1'b0;
                    sync3_r[gi] <= 1'b0;
                    lvl_r[gi] <= 1'b0;
                    lvl_prev_r[gi] <= 1'b0;
                end else begin
                    sync1_r[gi] <= raw_in[gi];
                    sync2_r[gi] <= sync1_r[gi];
                    sync3_r[gi] <= sync2_r[gi];
                    if (sync2_r[gi] == sync3_r[gi]) begin
                        lvl_r[gi] <= sync3_r[gi];
                    end
                    lvl_prev_r[gi] <= lvl_r[gi];
                end
            end
            assign rise[gi] = lvl_r[gi] & ~lvl_prev_r[gi];
        end
    endgenerate

    // registers
    reg meas_en_r;
    reg en_pend_r;
    reg en_pend_val_r;
    reg [7:0] en_dly_r;
    reg [7:0] tgt_edge_r;
    reg [7:0] ref_filt_r;
    reg [2:0] irq_en_r;
    reg ferr_r;
    reg mend_r;
    reg ovf_r;
    reg [15:0] upper_r;
    reg [15:0] lower_r;
    reg [15:0] capt_r;

    wire active = meas_en_r & ~module_stop;
    wire wr_en_byte = reg_wr && reg_addr == `CAM_OFS_MEAS_EN;
    wire wr_irq = reg_wr && reg_addr == `CAM_OFS_IRQ_EN;

    // target clock and count prescale
    wire tgt_tick = rise[clk_index(tgt_edge_r[`CAM_FLD_TGT_SEL])];
    reg [4:0] pre_cnt_r;
    reg [4:0] pre_mask;
    always @* begin
        case (tgt_edge_r[`CAM_FLD_PRESCALE])
            2'h1: pre_mask = 5'h03;
            2'h2: pre_mask = 5'h07;
            2'h3: pre_mask = 5'h1f;
            default: pre_mask = 5'h00;
        endcase
    end
    wire cnt_tick = tgt_tick && ((pre_cnt_r & pre_mask) == pre_mask);

    // internal reference: selected clock divided down, square wave from one divider bit
    wire int_tick = rise[clk_index(ref_filt_r[`CAM_FLD_INT_REF_SEL])];
    reg [12:0] ref_div_r;
    reg int_ref_lvl;
    always @* begin
        case (ref_filt_r[`CAM_FLD_REF_DIV])
            2'h1: int_ref_lvl = ref_div_r[6];
            2'h2: int_ref_lvl = ref_div_r[9];
            2'h3: int_ref_lvl = ref_div_r[12];
            default: int_ref_lvl = ref_div_r[4];
        endcase
    end

    // reference selection; pin gated by its own enable
    wire pin_ref = lvl_r[NSRC-1] & tgt_edge_r[`CAM_BIT_EXT_REF_EN];
    wire ref_raw = ref_filt_r[`CAM_BIT_REF_SRC] ? int_ref_lvl : pin_ref;

    // digital filter: level accepted after four equal samples
    reg [3:0] smp_cnt_r;
    reg [2:0] smp_hist_r;
    reg filt_lvl_r;
    reg smp_tick;
    always @* begin
        case (ref_filt_r[`CAM_FLD_FILT])
            2'h1: smp_tick = tgt_tick;
            2'h2: smp_tick = tgt_tick && smp_cnt_r[1:0] == 2'h3;
            2'h3: smp_tick = tgt_tick && smp_cnt_r == 4'hf;
            default: smp_tick = 1'b0;
        endcase
    end
    wire filt_on = ref_filt_r[`CAM_FLD_FILT] != 2'h0;
    wire ref_lvl = filt_on ? filt_lvl_r : ref_raw;
    reg ref_prev_r;
    reg ref_edge;
    always @* begin
        case (tgt_edge_r[`CAM_FLD_EDGE])
            2'h1: ref_edge = ref_prev_r & ~ref_lvl;
            2'h2: ref_edge = ref_prev_r ^ ref_lvl;
            default: ref_edge = ~ref_prev_r & ref_lvl;
        endcase
    end

    // measurement engine
    reg [1:0] state_r;
    reg [15:0] cnt_r;
    wire edge_run = active && state_r == ST_RUN && ref_edge;
    wire ovf_evt = active && state_r == ST_RUN && !ref_edge && cnt_tick && cnt_r == 16'hffff;
    wire out_range = cnt_r > upper_r || cnt_r < lower_r;

    always @(posedge clk_sys or negedge rst_n_r) begin
        if (!rst_n_r) begin
            pre_cnt_r <= 5'h00;
            ref_div_r <= 13'h0000;
            smp_cnt_r <= 4'h0;
            smp_hist_r <= 3'h0;
            filt_lvl_r <= 1'b0;
            ref_prev_r <= 1'b0;
            state_r <= ST_IDLE;
            cnt_r <= 16'h0000;
            capt_r <= 16'h0000;
        end else if (!active) begin
            // stopped or disabled: hold everything idle so the next start is clean
            pre_cnt_r <= 5'h00;
            ref_div_r <= 13'h0000;
            smp_cnt_r <= 4'h0;
            smp_hist_r <= {3{ref_raw}};
            filt_lvl_r <= ref_raw;
            ref_prev_r <= ref_raw;
            state_r <= ST_IDLE;
            cnt_r <= 16'h0000;
        end else begin
            if (tgt_tick) begin
                pre_cnt_r <= pre_cnt_r + 5'h01;
                smp_cnt_r <= smp_cnt_r + 4'h1;
            end
            if (int_tick) begin
                ref_div_r <= ref_div_r + 13'h0001;
            end
            if (smp_tick) begin
                smp_hist_r <= {smp_hist_r[1:0], ref_raw};
                if (smp_hist_r[1:0] == {2{ref_raw}} && smp_hist_r[2] == ref_raw) begin
                    filt_lvl_r <= ref_raw;
                end
            end
            ref_prev_r <= ref_lvl;
            case (state_r)
                ST_IDLE: begin
                    state_r <= ST_ARM;
                end
                ST_ARM: begin
                    if (ref_edge) begin
                        state_r <= ST_RUN;
                        cnt_r <= 16'h0000;
                        pre_cnt_r <= 5'h00;
                    end
                end
                ST_RUN: begin
                    if (ref_edge) begin
                        capt_r <= cnt_r;
                        cnt_r <= 16'h0000;
                        pre_cnt_r <= 5'h00;
                    end else if (cnt_tick) begin
                        cnt_r <= cnt_r + 16'h0001;
                    end
                end
                default: begin
                    state_r <= ST_IDLE;
                end
            endcase
        end
    end

    // register writes, enable delay and flags
    always @(posedge clk_sys or negedge rst_n_r) begin
        if (!rst_n_r) begin
            meas_en_r <= 1'b0;
            en_pend_r <= 1'b0;
            en_pend_val_r <= 1'b0;
            en_dly_r <= 8'h00;
            tgt_edge_r <= `CAM_RST_CTRL;
            ref_filt_r <= `CAM_RST_CTRL;
            irq_en_r <= 3'h0;
            upper_r <= `CAM_RST_LIMIT;
            lower_r <= `CAM_RST_LIMIT;
            ferr_r <= 1'b0;
            mend_r <= 1'b0;
            ovf_r <= 1'b0;
        end else begin
            // enable change lands late; writes meanwhile are dropped
            if (en_pend_r) begin
                if (en_dly_r == 8'h00) begin
                    meas_en_r <= en_pend_val_r;
                    en_pend_r <= 1'b0;
                end else begin
                    en_dly_r <= en_dly_r - 8'h01;
                end
            end else if (wr_en_byte) begin
                en_pend_r <= 1'b1;
                en_pend_val_r <= reg_wdata[`CAM_BIT_MEAS_EN];
                en_dly_r <= EN_DELAY[7:0] - 8'h01;
            end
            if (reg_wr) begin
                case (reg_addr)
                    `CAM_OFS_TGT_EDGE: tgt_edge_r <= reg_wdata;
                    `CAM_OFS_REF_FILT: ref_filt_r <= reg_wdata;
                    `CAM_OFS_IRQ_EN: irq_en_r <= reg_wdata[2:0];
                    `CAM_OFS_UPPER_LO: upper_r[7:0] <= reg_wdata;
                    `CAM_OFS_UPPER_HI: upper_r[15:8] <= reg_wdata;
                    `CAM_OFS_LOWER_LO: lower_r[7:0] <= reg_wdata;
                    `CAM_OFS_LOWER_HI: lower_r[15:8] <= reg_wdata;
                    default: ;
                endcase
            end
            // hardware set wins over a clear in the same cycle
            if (edge_run && out_range) begin
                ferr_r <= 1'b1;
            end else if (wr_irq && reg_wdata[`CAM_BIT_FERR_CLR]) begin
                ferr_r <= 1'b0;
            end
            if (edge_run) begin
                mend_r <= 1'b1;
            end else if (wr_irq && reg_wdata[`CAM_BIT_MEND_CLR]) begin
                mend_r <= 1'b0;
            end
            if (ovf_evt) begin
                ovf_r <= 1'b1;
            end else if (wr_irq && reg_wdata[`CAM_BIT_OVF_CLR]) begin
                ovf_r <= 1'b0;
            end
        end
    end

    // interrupt requests, read data
    always @(posedge clk_sys or negedge rst_n_r) begin
        if (!rst_n_r) begin
            irq_freq_error <= 1'b0;
            irq_measure_end <= 1'b0;
            irq_overflow <= 1'b0;
            reg_rdata <= 8'h00;
        end else begin
            irq_freq_error <= ferr_r & irq_en_r[0];
            irq_measure_end <= mend_r & irq_en_r[1];
            irq_overflow <= ovf_r & irq_en_r[2];
            if (reg_rd) begin
                case (reg_addr)
                    `CAM_OFS_MEAS_EN: reg_rdata <= {7'h00, meas_en_r};
                    `CAM_OFS_TGT_EDGE: reg_rdata <= tgt_edge_r;
                    `CAM_OFS_REF_FILT: reg_rdata <= ref_filt_r;
                    `CAM_OFS_IRQ_EN: reg_rdata <= {5'h00, irq_en_r};
                    `CAM_OFS_STATUS: reg_rdata <= {5'h00, ovf_r, mend_r, ferr_r};
                    `CAM_OFS_UPPER_LO: reg_rdata <= upper_r[7:0];
                    `CAM_OFS_UPPER_HI: reg_rdata <= upper_r[15:8];
                    `CAM_OFS_LOWER_LO: reg_rdata <= lower_r[7:0];
                    `CAM_OFS_LOWER_HI: reg_rdata <= lower_r[15:8];
                    `CAM_OFS_CAPT_LO: reg_rdata <= capt_r[7:0];
                    `CAM_OFS_CAPT_HI: reg_rdata <= capt_r[15:8];
                    default: reg_rdata <= 8'h00;
                endcase
            end else begin
                reg_rdata <= 8'h00;
            end
        end
    end

endmodule // cam_top

// ===== src/cam_consts.vh
// register offsets, field positions, reset values and timing for the clock accuracy monitor
`ifndef CAM_CONSTS_VH
`define CAM_CONSTS_VH

`define CAM_ADDR_W 20
`define CAM_OFS_MEAS_EN 20'h8b000
`define CAM_OFS_TGT_EDGE 20'h8b001
`define CAM_OFS_REF_FILT 20'h8b002
`define CAM_OFS_IRQ_EN 20'h8b003
`define CAM_OFS_STATUS 20'h8b004
`define CAM_OFS_UPPER_LO 20'h8b006
`define CAM_OFS_UPPER_HI 20'h8b007
`define CAM_OFS_LOWER_LO 20'h8b008
`define CAM_OFS_LOWER_HI 20'h8b009
`define CAM_OFS_CAPT_LO 20'h8b00a
`define CAM_OFS_CAPT_HI 20'h8b00b

`define CAM_BIT_MEAS_EN 0
`define CAM_BIT_EXT_REF_EN 0
`define CAM_FLD_TGT_SEL 3:1
`define CAM_FLD_PRESCALE 5:4
`define CAM_FLD_EDGE 7:6
`define CAM_BIT_REF_SRC 0
`define CAM_FLD_INT_REF_SEL 3:1
`define CAM_FLD_REF_DIV 5:4
`define CAM_FLD_FILT 7:6
`define CAM_BIT_FERR 0
`define CAM_BIT_MEND 1
`define CAM_BIT_OVF 2
`define CAM_BIT_FERR_CLR 4
`define CAM_BIT_MEND_CLR 5
`define CAM_BIT_OVF_CLR 6

`define CAM_RST_CTRL 8'h00
`define CAM_RST_LIMIT 16'h0000

`define CAM_EN_DELAY_NS 20
`define CAM_CLK_PERIOD_NS 5
`define CAM_EN_DELAY_CYC ((`CAM_EN_DELAY_NS + `CAM_CLK_PERIOD_NS - 1) / `CAM_CLK_PERIOD_NS)

`endif

// ===== test/cam_props.sv
// concurrent checks on the register port and interrupt outputs of the monitor
`timescale 1ns/1ps
`include "cam_consts.vh"
module cam_props (
    // clock and reset
    input wire clk_sys,
    input wire reset_n,
    // register port
    input wire [`CAM_ADDR_W-1:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    input wire [7:0] reg_rdata,
    // interrupt requests
    input wire irq_freq_error,
    input wire irq_measure_end,
    input wire irq_overflow
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    // mirror of the enables, so gating is judged without seeing inside
    reg [2:0] ien_r;
    wire clr_wr = reg_wr && reg_addr == `CAM_OFS_IRQ_EN;
    always @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            ien_r <= 3'h0;
        end else if (clr_wr) begin
            ien_r <= reg_wdata[2:0];
        end
    end
    sequence s_rd(logic [19:0] a);
        reg_rd && reg_addr == a;
    endsequence
    // request high, with no clear write in that cycle or the one before
    sequence s_held(logic x);
        !clr_wr ##1 (x && !clr_wr);
    endsequence
    property p_rsvd(logic [19:0] a, logic [7:0] m);
        s_rd(a) |=> (reg_rdata & m) == 8'h00;
    endproperty
    a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 8'h00)
        else $error("read data not zero outside a read");
    a_enable_rsvd: assert property (p_rsvd(`CAM_OFS_MEAS_EN, 8'hfe))
        else $error("enable register upper bits not zero");
    a_clear_bits_zero: assert property (p_rsvd(`CAM_OFS_IRQ_EN, 8'hf8))
        else $error("clear bits not read as zero");
    a_status_rsvd: assert property (p_rsvd(`CAM_OFS_STATUS, 8'hf8))
        else $error("status upper bits not zero");
    a_unmapped_zero: assert property (reg_rd && (reg_addr == 20'h8b005 ||
        reg_addr > 20'h8b00b || reg_addr < 20'h8b000) |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    a_irq_gated: assert property (({irq_overflow, irq_measure_end, irq_freq_error}
        & ~$past(ien_r)) == 3'h0)
        else $error("request without its enable");
    a_mend_sticky: assert property (s_held(irq_measure_end) |=> irq_measure_end)
        else $error("end request dropped without clear");
    a_ferr_sticky: assert property (s_held(irq_freq_error) |=> irq_freq_error)
        else $error("error request dropped without clear");
    a_status_mend: assert property (!clr_wr ##1 (s_rd(`CAM_OFS_STATUS)
        and irq_measure_end) |=> reg_rdata[`CAM_BIT_MEND])
        else $error("status end bit low while request high");
endmodule // cam_props

// ===== test/cam_ref_src.sv
// external reference source driving the reference pin
`timescale 1ns/1ps
module cam_ref_src #(
    parameter int HALF_NS = 3200
) (
    // control
    input wire run,
    // reference pin
    output logic ref_out
);
    // free running, offset so its edges never meet the system clock edge
    initial begin
        ref_out = 1'b0;
        #1.3;
        forever #(HALF_NS) ref_out = run ? ~ref_out : ref_out;
    end
endmodule // cam_ref_src

// ===== test/test_cam_top.sv
// self-checking bench for the clock accuracy monitor with a count model
`timescale 1ns/1ps
`include "cam_consts.vh"
module test_cam_top;
    localparam int EN_DLY = 4;
    localparam int REF_NS = 6400;
    localparam int TOL = 6;
    localparam int TP [5] = '{40, 36, 100, 80, 50};
    logic clk_sys = 1'b0;
    logic reset_n = 1'b0;
    logic module_stop = 1'b0;
    logic [4:0] tck = 5'h00;
    wire ext_reference_pin;
    logic [19:0] reg_addr = 20'h00000;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    wire [7:0] reg_rdata;
    wire irq_freq_error;
    wire irq_measure_end;
    wire irq_overflow;
    int errors = 0;
    int total_checks = 0;
    logic [7:0] d;
    logic [15:0] lim;
    // c1, c2, offset of the limits from the true count
    logic [23:0] tbl [18] = '{24'h010000, 24'h110000, 24'h210000, 24'h310000, 24'h410000,
        24'h810000, 24'h050000, 24'h070000, 24'h090000, 24'h0b0000, 24'h014000, 24'h018000,
        24'h31c000, 24'h000100, 24'h001500, 24'h000900, 24'h002100, 24'h010014};
    always #2.5 clk_sys = ~clk_sys;
    for (genvar g = 0; g < 5; g++) begin : g_tck
        initial begin
            #0.7;
            forever #(TP[g] / 2.0) tck[g] = ~tck[g];
        end
    end
    cam_ref_src #(.HALF_NS(REF_NS / 2)) u_cam_ref_src (.run(1'b1), .ref_out(ext_reference_pin));
    cam_top #(.EN_DELAY(EN_DLY)) u_cam_top (.clk_sys(clk_sys), .reset_n(reset_n),
        .module_stop(module_stop), .main_clock(tck[0]), .high_speed_onchip_osc(tck[1]),
        .low_speed_onchip_osc(tck[2]), .watchdog_dedicated_clock(tck[3]),
        .peripheral_clock_b(tck[4]), .ext_reference_pin(ext_reference_pin),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .irq_freq_error(irq_freq_error),
        .irq_measure_end(irq_measure_end), .irq_overflow(irq_overflow));
    task automatic summarize();
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic check(input string n, input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            errors++;
            $display("BAD %s expected %h seen %h", n, exp, seen);
        end
    endtask
    task automatic wr(input logic [19:0] a, input logic [7:0] v);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [19:0] a, output logic [7:0] v);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        // data stand for the one cycle after the strobe; take them at its closing edge
        @(posedge clk_sys);
        v = reg_rdata;
    endtask
    task automatic wr16(input logic [19:0] a, input logic [15:0] v);
        wr(a, v[7:0]);
        wr(a + 20'h1, v[15:8]);
    endtask
    function automatic int tp(input logic [2:0] c);
        return TP[c < 2 ? 0 : c - 1];
    endfunction
    // count expected per reference period from the clock periods and dividers
    function automatic int model(input logic [7:0] c1, input logic [7:0] c2);
        int pd [4] = '{1, 4, 8, 32};
        int rdv [4] = '{32, 128, 1024, 8192};
        int r;
        r = c2[0] ? tp(c2[3:1]) * rdv[c2[5:4]] : REF_NS / (c1[7:6] == 2'd2 ? 2 : 1);
        return r / (tp(c1[3:1]) * pd[c1[5:4]]);
    endfunction
    task automatic measure(input logic [7:0] c1, input logic [7:0] c2, input int off);
        int ex;
        int lo_b;
        int i;
        logic [7:0] lo;
        logic [7:0] hi;
        ex = model(c1, c2);
        lo_b = ex > TOL ? ex - TOL : 0;
        wr(`CAM_OFS_MEAS_EN, 8'h00);
        repeat (EN_DLY) @(posedge clk_sys);
        wr(`CAM_OFS_TGT_EDGE, c1);
        wr(`CAM_OFS_REF_FILT, c2);
        wr16(`CAM_OFS_UPPER_LO, 16'(ex + off + TOL));
        wr16(`CAM_OFS_LOWER_LO, 16'(lo_b + off));
        wr(`CAM_OFS_IRQ_EN, off > 0 ? 8'h73 : 8'h72);
        wr(`CAM_OFS_MEAS_EN, 8'h01);
        for (i = 0; i < 20000 && irq_measure_end !== 1'b1; i++) @(posedge clk_sys);
        if (i == 20000) begin
            errors++;
            summarize();
        end
        check("irq_err", irq_freq_error, off > 0);
        rd(`CAM_OFS_CAPT_LO, lo);
        rd(`CAM_OFS_CAPT_HI, hi);
        check("capture", 16'({hi, lo} >= 16'(lo_b) && {hi, lo} <= 16'(ex + TOL)), 16'h1);
        rd(`CAM_OFS_STATUS, lo);
        check("status", lo, off != 0 ? 8'h03 : 8'h02);
    endtask
    initial begin
        void'($urandom(1223));
        repeat (4) @(posedge clk_sys);
        reset_n <= 1'b1;
        repeat (3) @(posedge clk_sys);
        for (int a = 0; a < 13; a++) begin
            rd(20'h8b000 + 20'(a), d);
            check("reset", d, 8'h00);
        end
        rd(20'h8c000, d);
        check("unmapped", d, 8'h00);
        lim = 16'($urandom);
        wr16(`CAM_OFS_UPPER_LO, lim);
        wr(`CAM_OFS_CAPT_LO, 8'h5a);
        rd(`CAM_OFS_UPPER_HI, d);
        check("upper", d, lim[15:8]);
        rd(`CAM_OFS_CAPT_LO, d);
        check("capt_ro", d, 8'h00);
        wr(`CAM_OFS_IRQ_EN, 8'h77);
        rd(`CAM_OFS_IRQ_EN, d);
        check("irq_en", d, 8'h07);
        wr(`CAM_OFS_MEAS_EN, {7'($urandom), 1'b1});
        rd(`CAM_OFS_MEAS_EN, d);
        check("en_early", d, 8'h00);
        repeat (EN_DLY) @(posedge clk_sys);
        rd(`CAM_OFS_MEAS_EN, d);
        check("en_late", d, 8'h01);
        wr(`CAM_OFS_MEAS_EN, 8'h00);
        wr(`CAM_OFS_MEAS_EN, 8'h01);
        repeat (EN_DLY) @(posedge clk_sys);
        rd(`CAM_OFS_MEAS_EN, d);
        check("en_drop", d, 8'h00);
        for (int t = 0; t < 18; t++) measure(tbl[t][23:16], tbl[t][15:8], 32'(signed'(tbl[t][7:0])));
        measure(8'h01, 8'h00, -20);
        // a stopped engine must not finish a measurement
        module_stop <= 1'b1;
        wr(`CAM_OFS_IRQ_EN, 8'h72);
        repeat (3 * REF_NS / 5) @(posedge clk_sys);
        rd(`CAM_OFS_STATUS, d);
        check("stopped", d, 8'h00);
        summarize();
    end
endmodule // test_cam_top
bind cam_top cam_props u_cam_props (.clk_sys(clk_sys), .reset_n(reset_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .irq_freq_error(irq_freq_error), .irq_measure_end(irq_measure_end),
    .irq_overflow(irq_overflow));
